// [rtl/qdac_consts.vh]
// Constants for the quad converter serial control block
`ifndef QDAC_CONSTS_VH
`define QDAC_CONSTS_VH
`define QDAC_WORD_BITS 16
`define QDAC_CODE_BITS 10
`define QDAC_CODE_MSB 13
`define QDAC_CODE_LSB 4
`define QDAC_SEL_MSB 15
`define QDAC_CTL_MSB 13
`define QDAC_CMD_MSB 15
`define QDAC_CMD_LSB 12
`define QDAC_CODE_RESET 10'h000
`define QDAC_CMD_NOP 2'h0
`define QDAC_CMD_UPO 2'h2
`define QDAC_CMD_LOAD 2'h1
`define QDAC_CMD_LOAD_UPD 2'h3
`define QDAC_SEL_UPDATE 2'h1
`define QDAC_SEL_LOADALL 2'h2
`define QDAC_SEL_SHUTDOWN 2'h3
`define QDAC_SEL_UPO_LO 2'h0
`define QDAC_SEL_UPO_HI 2'h1
`define QDAC_SEL_MODE0 2'h2
`define QDAC_SEL_MODE1 2'h3
`define QDAC_MODE_RESET 1'b0
`endif

// [rtl/qdac_sync.v]
// Two-stage synchroniser with edge detection for one pin
`timescale 1ns/1ps
module qdac_sync #(
    parameter RESET_VAL = 1'b0
) (
    input wire clk,
    input wire rst,
    input wire pin,
    output wire level,
    output wire rise,
    output wire fall
);
    reg meta_q;
    reg sync_q;
    reg prev_q;

    // First stage feeds only the second; edges come from later stages
    always @(posedge clk) begin
        if (rst) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
            prev_q <= RESET_VAL;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;
endmodule

// [rtl/quad_dac_serial_shutdown_ctrl.v]
// Serial control, shutdown and register state of a quad 10-bit converter
`timescale 1ns/1ps
`include "qdac_consts.vh"
module quad_dac_serial_shutdown_ctrl (
    input wire CLK,
    input wire SYS_RST,
    input wire CS_N,
    input wire SERIAL_CLK,
    input wire SERIAL_DIN,
    input wire SHUTDOWN_LOCKOUT_IN,
    output reg SERIAL_DOUT,
    output reg UPO,
    output reg SHUTDOWN,
    output reg DOUT_MODE,
    output reg [`QDAC_CODE_BITS-1:0] CODE_A,
    output reg [`QDAC_CODE_BITS-1:0] CODE_B,
    output reg [`QDAC_CODE_BITS-1:0] CODE_C,
    output reg [`QDAC_CODE_BITS-1:0] CODE_D
);
    // ******************************************************
    // Pin synchronisation
    // ******************************************************
    wire cs_n_s;
    wire cs_rise;
    wire sclk_rise;
    wire sclk_fall;
    wire din_s;
    wire lock_s;
    wire lock_fall;

    qdac_sync #(.RESET_VAL(1'b1)) u_cs (
        .clk(CLK), .rst(SYS_RST), .pin(CS_N),
        .level(cs_n_s), .rise(cs_rise), .fall()
    );
    qdac_sync #(.RESET_VAL(1'b0)) u_sclk (
        .clk(CLK), .rst(SYS_RST), .pin(SERIAL_CLK),
        .level(), .rise(sclk_rise), .fall(sclk_fall)
    );
    // Data goes through the same depth so it lines up with the clock edge
    qdac_sync #(.RESET_VAL(1'b0)) u_din (
        .clk(CLK), .rst(SYS_RST), .pin(SERIAL_DIN),
        .level(din_s), .rise(), .fall()
    );
    qdac_sync #(.RESET_VAL(1'b1)) u_lock (
        .clk(CLK), .rst(SYS_RST), .pin(SHUTDOWN_LOCKOUT_IN),
        .level(lock_s), .rise(), .fall(lock_fall)
    );

    // ******************************************************
    // Shift register and command decode
    // ******************************************************
    reg [`QDAC_WORD_BITS-1:0] shift_q;
    reg [`QDAC_CODE_BITS-1:0] input_q [0:3];
    reg [`QDAC_CODE_BITS-1:0] dac_q [0:3];
    wire [1:0] sel_bits = shift_q[`QDAC_SEL_MSB:`QDAC_SEL_MSB-1];
    wire [1:0] ctl_bits = shift_q[`QDAC_CTL_MSB:`QDAC_CTL_MSB-1];
    // Code field MSB first; the two pad bits below it are ignored
    wire [`QDAC_CODE_BITS-1:0] code_field = shift_q[`QDAC_CODE_MSB-2:`QDAC_CODE_LSB-2];
    wire load_cmd = cs_rise & ctl_bits[0];
    wire upd_all = cs_rise & (((ctl_bits == `QDAC_CMD_NOP) & (sel_bits == `QDAC_SEL_UPDATE))
        | (ctl_bits == `QDAC_CMD_LOAD_UPD)
        | ((ctl_bits == `QDAC_CMD_UPO) & sel_bits[1]));
    wire load_all = cs_rise & (ctl_bits == `QDAC_CMD_NOP) & (sel_bits == `QDAC_SEL_LOADALL);
    wire sd_cmd = cs_rise & (ctl_bits == `QDAC_CMD_NOP) & (sel_bits == `QDAC_SEL_SHUTDOWN);
    wire upo_cmd = cs_rise & (ctl_bits == `QDAC_CMD_UPO) & ~sel_bits[1];
    wire mode_cmd = cs_rise & (ctl_bits == `QDAC_CMD_UPO) & sel_bits[1];

    always @(posedge CLK) begin
        if (SYS_RST) begin
            shift_q <= {`QDAC_WORD_BITS{1'b0}};
        end else if (!cs_n_s && sclk_rise) begin
            shift_q <= {shift_q[`QDAC_WORD_BITS-2:0], din_s};
        end
    end

    // ******************************************************
    // Input and converter registers, one slice per channel
    // ******************************************************
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1) begin : g_chan
            // Channel index held at the select field's width
            localparam [1:0] CH_IDX = ch;
            wire hit = load_cmd & (sel_bits == CH_IDX);
            always @(posedge CLK) begin
                if (SYS_RST) begin
                    input_q[ch] <= `QDAC_CODE_RESET;
                    dac_q[ch] <= `QDAC_CODE_RESET;
                end else begin
                    if (hit || load_all) begin
                        input_q[ch] <= code_field;
                    end
                    if (load_all) begin
                        dac_q[ch] <= code_field;
                    end else if (upd_all) begin
                        dac_q[ch] <= hit ? code_field : input_q[ch];
                    end
                end
            end
        end
    endgenerate

    // Converter outputs are registered copies; codes pass untouched in
    // either unipolar or offset-binary (bipolar) use
    // Code passed unchanged
    always @(posedge CLK) begin
        if (SYS_RST) begin
            CODE_A <= `QDAC_CODE_RESET;
            CODE_B <= `QDAC_CODE_RESET;
            CODE_C <= `QDAC_CODE_RESET;
            CODE_D <= `QDAC_CODE_RESET;
        end else begin
            CODE_A <= dac_q[0];
            CODE_B <= dac_q[1];
            CODE_C <= dac_q[2];
            CODE_D <= dac_q[3];
        end
    end

    // ******************************************************
    // Shutdown, lockout, user output and mode
    // ******************************************************
    // Shutdown only gates the analog side; codes are kept so wake restores them
    always @(posedge CLK) begin
        if (SYS_RST) begin
            SHUTDOWN <= 1'b0;
        end else if (lock_fall) begin
            SHUTDOWN <= 1'b0;
        end else if (sd_cmd && lock_s) begin
            SHUTDOWN <= 1'b1;
        end else if (load_all || (cs_rise && ctl_bits == `QDAC_CMD_NOP
                     && sel_bits == `QDAC_SEL_UPDATE)) begin
            SHUTDOWN <= 1'b0;
        end
    end

    always @(posedge CLK) begin
        if (SYS_RST) begin
            UPO <= 1'b0;
            DOUT_MODE <= `QDAC_MODE_RESET;
        end else begin
            if (upo_cmd) begin
                UPO <= sel_bits[0];
            end
            if (mode_cmd) begin
                DOUT_MODE <= sel_bits[0];
            end
        end
    end

    // ******************************************************
    // Serial data out
    // ******************************************************
    // Chain output timing
    // Mode 1 shows the word's oldest bit from the rising edge (16 cycles);
    // mode 0 holds it until the falling edge (16.5 cycles)
    always @(posedge CLK) begin
        if (SYS_RST) begin
            SERIAL_DOUT <= 1'b0;
        end else if (!cs_n_s) begin
            if (DOUT_MODE && sclk_rise) begin
                SERIAL_DOUT <= shift_q[`QDAC_WORD_BITS-2];
            end else if (!DOUT_MODE && sclk_fall) begin
                SERIAL_DOUT <= shift_q[`QDAC_WORD_BITS-1];
            end
        end
    end
endmodule

// [tb/qdac_chk.sv]
// Port assertions for the converter control block
`timescale 1ns/1ps
module qdac_chk (
    input wire CLK,
    input wire SYS_RST,
    input wire CS_N,
    input wire SHUTDOWN_LOCKOUT_IN,
    input wire UPO,
    input wire SHUTDOWN,
    input wire DOUT_MODE,
    input wire [9:0] CODE_A,
    input wire [9:0] CODE_B,
    input wire [9:0] CODE_C,
    input wire [9:0] CODE_D
);
    // Codes grouped so one check covers all four
    wire [39:0] codes = {CODE_A, CODE_B, CODE_C, CODE_D};
    wire lo = SHUTDOWN_LOCKOUT_IN;
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    chk_reset_codes: assert property ($fell(SYS_RST) |-> codes == 40'h0)
        else $error("codes not clear");
    chk_reset_mode: assert property ($fell(SYS_RST) |-> !DOUT_MODE && !UPO)
        else $error("mode not clear");
    chk_lock_block: assert property (!lo [*5] ##0 !SHUTDOWN |=> !SHUTDOWN)
        else $error("shutdown while locked");
    chk_lock_wake: assert property ($fell(lo) && SHUTDOWN |-> ##[1:6] !SHUTDOWN)
        else $error("no lockout wake");
    chk_idle_hold: assert property (CS_N [*8] |-> $stable(codes))
        else $error("codes moved idle");
    chk_code_cause: assert property (!$stable(codes) |-> CS_N)
        else $error("codes moved selected");
    chk_ctl_cause: assert property (!$stable({UPO, DOUT_MODE}) |-> CS_N)
        else $error("control moved selected");
    chk_shut_cause: assert property ($rose(SHUTDOWN) |-> CS_N && $past(lo, 3))
        else $error("shutdown without cause");
endmodule
bind quad_dac_serial_shutdown_ctrl qdac_chk chk_i (.*);

// [tb/qdac_host_model.sv]
// Serial host model framing commands into the block
`timescale 1ns/1ps
module qdac_host_model (
    input wire CLK,
    input wire DOUT,
    output reg CS_N,
    output reg SCLK,
    output reg DIN
);
    reg [31:0] got;
    // Idle: deselected, clock parked low between frames
    initial begin
        CS_N = 1'b1;
        SCLK = 1'b0;
        DIN = 1'b0;
    end
    // one data line, this model owns the only select
    task frame(input [31:0] w, input integer n);
        integer i;
        begin
            CS_N <= 1'b0;
            for (i = n - 1; i >= 0; i = i - 1) begin
                DIN <= w[i];
                repeat (4) @(posedge CLK);
                // chained output taken at each rise
                got <= {got[30:0], DOUT};
                SCLK <= 1'b1;
                repeat (4) @(posedge CLK);
                SCLK <= 1'b0;
            end
            repeat (4) @(posedge CLK);
            CS_N <= 1'b1;
            // Released line flips so a stale bit cannot pass
            DIN <= ~DIN;
            repeat (10) @(posedge CLK);
        end
    endtask
endmodule

// [tb/quad_dac_serial_shutdown_ctrl_bench.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module quad_dac_serial_shutdown_ctrl_bench;
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg lo = 1'b1;
    integer err_total = 0, checked = 0, cyc = 0;
    wire cs_n, sclk, din, dout, upo, shut, mode;
    wire [9:0] code_a, code_b, code_c, code_d;
    qdac_host_model qdac_host_model_i (.CLK(clk), .DOUT(dout), .CS_N(cs_n), .SCLK(sclk),
        .DIN(din));
    quad_dac_serial_shutdown_ctrl quad_dac_serial_shutdown_ctrl_i (.CLK(clk),
        .SYS_RST(sys_rst), .CS_N(cs_n), .SERIAL_CLK(sclk), .SERIAL_DIN(din),
        .SHUTDOWN_LOCKOUT_IN(lo), .SERIAL_DOUT(dout), .UPO(upo), .SHUTDOWN(shut),
        .DOUT_MODE(mode), .CODE_A(code_a), .CODE_B(code_b), .CODE_C(code_c),
        .CODE_D(code_d));
    // 125 MHz clock and a hang limit
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_total++;
            print_verdict;
        end
    end
    task print_verdict;
        begin
            $display("checked %0d failed %0d", checked, err_total);
            if (err_total == 0 && checked > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    task send(input [31:0] w, input integer n);
        qdac_host_model_i.frame(w, n);
    endtask
    task t_reset;
        begin
            `CHK("codes", 40'h0, {code_a, code_b, code_c, code_d})
            `CHK("mode upo", 2'b00, {mode, upo})
            $display("test reset done");
        end
    endtask
    // Load-only must wait for update; pads and spare bits ignored
    task t_load;
        begin
            send(32'h3FFC, 16);
            `CHK("code_a", 10'h3FF, code_a)
            send(32'h5557, 16);
            `CHK("b held", 10'h000, code_b)
            send(32'h4FFF, 16);
            `CHK("code_b", 10'h155, code_b)
            send(32'h0FFF, 16);
            `CHK("nop", 20'hFFD55, {code_a, code_b})
            $display("test load done");
        end
    endtask
    task t_shut;
        begin
            send(32'hC000, 16);
            `CHK("shut", 1'b1, shut)
            lo <= 1'b0;
            repeat (10) @(posedge clk);
            `CHK("woken", 11'h3FF, {shut, code_a})
            send(32'hC000, 16);
            `CHK("locked", 1'b0, shut)
            lo <= 1'b1;
            send(32'hC000, 16);
            send(32'h4000, 16);
            `CHK("upd wake", 1'b0, shut)
            $display("test shut done");
        end
    endtask
    task t_mode;
        begin
            send(32'h6000, 16);
            `CHK("upo hi", 1'b1, upo)
            send(32'h2000, 16);
            `CHK("upo lo", 1'b0, upo)
            send(32'hE000, 16);
            `CHK("mode 1", 1'b1, mode)
            send(32'hA000, 16);
            `CHK("mode 0", 1'b0, mode)
            $display("test mode done");
        end
    endtask
    // Two words in one window: first passes on, second is kept
    task t_chain;
        begin
            send(32'hC000, 16);
            send(32'hA5C38800, 32);
            `CHK("chain", 16'hA5C3, qdac_host_model_i.got[15:0])
            `CHK("all", 41'h8020080200, {shut, code_a, code_b, code_c, code_d})
            // Rising-edge output mode passes the same word on
            send(32'hE000, 16);
            send(32'hC000, 16);
            send(32'hA5C38800, 32);
            `CHK("chain m1", 16'hA5C3, qdac_host_model_i.got[15:0])
            `CHK("all m1", 42'h28020080200, {mode, shut, code_a, code_b, code_c, code_d})
            $display("test chain done");
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset;
        t_load;
        t_shut;
        t_mode;
        t_chain;
        print_verdict;
    end
endmodule
